// ==== uecr_host_model.sv ====
`timescale 1ns/10ps
// Behavioural USB host and serial engine facing the endpoint control block.
// Assumes the testbench calls one task at a time.
module uecr_host_model
  import uecr_pkg::*;
#(
  parameter int NEP = 3
) (
  // Clock
  input wire logic                clk_sys,
  // Block side
  input wire uecr_txv_t [NEP-1:0] ep_txv,
  output uecr_ev_t [NEP-1:0]      ep_ev,
  output logic                    usb_reset_seen
);
  // --------------------------------------------------
  // Transactions
  // --------------------------------------------------
  initial begin
    ep_ev = '0;
    usb_reset_seen = 1'b0;
  end

  task in_xfer(input int ep);
    @(posedge clk_sys);
    ep_ev[ep].in_token <= 1'b1;
    @(posedge clk_sys);
    ep_ev[ep].in_token <= 1'b0;
    @(posedge clk_sys);
    // Host acknowledges only a data packet, never a refusal
    if (ep_txv[ep].answer === UECR_ANS_DATA) begin
      ep_ev[ep].host_ack <= 1'b1;
      @(posedge clk_sys);
      ep_ev[ep].host_ack <= 1'b0;
    end
  endtask

  task out_xfer(input int ep, input logic [6:0] n);
    @(posedge clk_sys);
    ep_ev[ep].rx_done <= 1'b1;
    ep_ev[ep].rx_bytes <= n;
    @(posedge clk_sys);
    ep_ev[ep].rx_done <= 1'b0;
    // Count is unqualified now, so leave no stale value on it
    ep_ev[ep].rx_bytes <= ~n;
  endtask

  task bus_reset();
    @(posedge clk_sys);
    usb_reset_seen <= 1'b1;
    repeat (6) @(posedge clk_sys);
    usb_reset_seen <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// ==== uecr_map.svh ====
// Register map, field positions and reset values of the endpoint control block.
// Assumes word indices on an APB bus with 32-bit data, one register per word.
`ifndef UECR_MAP_SVH
`define UECR_MAP_SVH

`define UECR_IDX_ISTR      8'h30
`define UECR_IDX_IMR       8'h31
`define UECR_IDX_CTL       8'h32
`define UECR_IDX_DEVICE_ADDRESS     8'h33
`define UECR_IDX_LSTAT     8'h34
`define UECR_IDX_EP0       8'h35
`define UECR_IDX_C0RX      8'h36
`define UECR_IDX_C0TX      8'h37
`define UECR_IDX_EP1RX     8'h38
`define UECR_IDX_C1RX      8'h39
`define UECR_IDX_EP1TX     8'h3A
`define UECR_IDX_C1TX      8'h3B
`define UECR_IDX_EP2RX     8'h3C
`define UECR_IDX_C2RX      8'h3D
`define UECR_IDX_EP2TX     8'h3E
`define UECR_IDX_C2TX      8'h3F
`define UECR_IDX_BUFCS     8'h47

`define UECR_ADDR_LSB      2
`define UECR_ADDR_W        8

`define UECR_CTL_FORCE_BUS_RESET      0
`define UECR_ISTR_RESET    1
`define UECR_ISTR_CTR      7
`define UECR_ISTR_RST      8'h00
`define UECR_IMR_RST       8'h00
`define UECR_CTL_RST       8'h06
`define UECR_EP_DONE       3
`define UECR_EP0_DONE      7
`define UECR_EP_TOG        2
`define UECR_EP2_MODE_HI   7
`define UECR_EP2_MODE_LO   6
`define UECR_CNT_RST       7'h00
`define UECR_BYTE_ZERO     8'h00
`define UECR_WORD_ZERO     32'h0000_0000

`endif

// ==== uecr_pkg.sv ====
// Types shared by the endpoint control block.
// Assumes the map header is included where offsets are needed.
package uecr_pkg;

  typedef enum logic [1:0] {
    UECR_HS_DISABLED = 2'h0,
    UECR_HS_STALL    = 2'h1,
    UECR_HS_NAK      = 2'h2,
    UECR_HS_VALID    = 2'h3
  } uecr_hs_t;

  typedef enum logic [1:0] {
    UECR_MODE_NORMAL   = 2'h0,
    UECR_MODE_UPLOAD   = 2'h1,
    UECR_MODE_DOWNLOAD = 2'h2,
    UECR_MODE_RSVD     = 2'h3
  } uecr_mode_t;

  typedef enum logic [1:0] {
    UECR_ANS_NONE  = 2'h0,
    UECR_ANS_DATA  = 2'h1,
    UECR_ANS_NAK   = 2'h2,
    UECR_ANS_STALL = 2'h3
  } uecr_ans_t;

  // One transaction event from the serial engine for a single endpoint
  typedef struct packed {
    logic       in_token;
    logic       host_ack;
    logic       rx_done;
    logic [6:0] rx_bytes;
  } uecr_ev_t;

  // Transmit side view of one endpoint handed to the serial engine
  typedef struct packed {
    uecr_ans_t  answer;
    logic       toggle;
    logic [6:0] tx_bytes;
  } uecr_txv_t;

endpackage

// ==== uecr_properties.sv ====
`timescale 1ns/10ps
// Concurrent checks on the ports of the endpoint control block.
// Assumes it is bound onto uecr_top; everything runs on clk_sys.
module uecr_properties
  import uecr_pkg::*;
#(
  parameter int NEP  = 3,
  parameter int CW01 = 5,
  parameter int CW2  = 7
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst_n,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Link side
  input wire logic                usb_reset_seen,
  input wire uecr_ev_t [NEP-1:0]  ep_ev,
  input wire uecr_txv_t [NEP-1:0] ep_txv,
  input wire logic [NEP-1:0]      rx_tog,
  input wire logic                irq
);
  // --------------------------------------------------
  // Properties
  // --------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_BUS_RESET_CLEARS: assert property (
    usb_reset_seen [*4] |-> ##[0:2] (ep_txv[2].answer == UECR_ANS_NONE && !ep_txv[2].toggle))
    else $error("bus reset left endpoint 2 state");
  AST_ACK_FORCES_NAK: assert property (
    ep_ev[1].host_ack && ep_txv[1].answer == UECR_ANS_DATA |-> ##[1:2]
    ep_txv[1].answer == UECR_ANS_NAK)
    else $error("handshake not NAK after transfer");
  AST_ACK_FLIPS: assert property (
    ep_ev[2].host_ack && ep_txv[2].answer == UECR_ANS_DATA && !ep_txv[2].toggle
    |-> ##[1:2] ep_txv[2].toggle)
    else $error("toggle did not flip on ack");
  AST_REFUSE_HOLDS: assert property (
    ep_ev[2].in_token && ep_txv[2].answer inside {UECR_ANS_STALL, UECR_ANS_NAK}
    |=> $stable(ep_txv[2].answer))
    else $error("refusal state changed by request");
  AST_EP01_WIDTH: assert property (
    ep_txv[0].tx_bytes[6:5] == 2'h0 && ep_txv[1].tx_bytes[6:5] == 2'h0)
    else $error("endpoint 0 or 1 count wider than five bits");

  COV_ACK: cover property (ep_ev[1].host_ack && ep_txv[1].answer == UECR_ANS_DATA);
  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (pslverr);
endmodule

// ==== uecr_tb.sv ====
`timescale 1ns/10ps
// Self-checking testbench of the endpoint control block.
// Assumes uecr_top, the host model and the property checker are compiled first.
`include "uecr_map.svh"
module testbench
  import uecr_pkg::*;
;
  localparam int NEP = 3;
  logic                  clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic                  usb_reset_seen, irq, err;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, q;
  uecr_ev_t [NEP-1:0]    ep_ev;
  uecr_txv_t [NEP-1:0]   ep_txv;
  logic [NEP-1:0]        rx_tog;
  logic [7:0]            seed, o;
  int                    fails, cmp_count, cap;
  logic [7:0]            rxc[3] = '{8'h36, 8'h39, 8'h3D};
  logic [7:0]            txc[3] = '{8'h37, 8'h3B, 8'h3F};
  logic [7:0]            rxo[3] = '{8'h35, 8'h38, 8'h3C};
  int                    msk[3] = '{31, 31, 127};
  logic [1:0]            exp_ans[4] = '{2'h0, 2'h3, 2'h2, 2'h1};

  uecr_top #(.NEP(NEP), .CW01(5), .CW2(7)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_reset_seen(usb_reset_seen),
    .ep_ev(ep_ev), .ep_txv(ep_txv), .rx_tog(rx_tog), .irq(irq));
  uecr_host_model #(.NEP(NEP)) u_host (.clk_sys(clk_sys), .ep_txv(ep_txv), .ep_ev(ep_ev),
    .usb_reset_seen(usb_reset_seen));

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task give_verdict;
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for pready without assuming a latency
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, a, 2'h0};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      give_verdict;
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q & m);
  endtask

  // --------------------------------------------------
  // Stimulus
  // --------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    give_verdict;
  end

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fails = 0;
    cmp_count = 0;
    seed = 8'h0F;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rxc[i]) begin
      rdc(rxc[i], 32'hFF, 32'h00, "rx count reset");
      rdc(txc[i], 32'hFF, 32'h00, "tx count reset");
    end
    rdc(`UECR_IDX_EP2TX, 32'hFF, 32'h00, "ep2 tx reset");
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'h1, err);
    chk("unmapped data", 32'h0, q);
    foreach (rxc[i]) begin
      seed = lfsr(seed);
      cap = seed & msk[i];
      apb(1'b1, rxo[i], 32'h03);
      apb(1'b1, rxc[i], {24'h0, seed});
      u_host.out_xfer(i, 7'(cap / 2));
      rdc(rxc[i], 32'hFF, cap - cap / 2, "rx count left");
      seed = lfsr(seed);
      apb(1'b1, txc[i], {24'h0, seed});
      repeat (2) @(posedge clk_sys);
      chk("tx bytes", seed & msk[i], ep_txv[i].tx_bytes);
    end
    apb(1'b0, `UECR_IDX_ISTR, 32'h0);
    for (int h = 0; h < 4; h++) begin
      apb(1'b1, `UECR_IDX_EP2TX, h);
      repeat (2) @(posedge clk_sys);
      chk("answer", exp_ans[h], ep_txv[2].answer);
      if (h < 3) begin
        u_host.in_xfer(2);
        chk("answer after request", exp_ans[h], ep_txv[2].answer);
      end
    end
    apb(1'b1, `UECR_IDX_IMR, 32'h80);
    for (int e = 1; e < 3; e++) begin
      o = (e == 1) ? `UECR_IDX_EP1TX : `UECR_IDX_EP2TX;
      apb(1'b1, o, 32'h03);
      u_host.in_xfer(e);
      rdc(o, 32'hFF, 32'h0E, "ctl after ack");
      chk("irq set", 32'h1, irq);
      rdc(`UECR_IDX_ISTR, 32'h80, 32'h80, "status transfer bit");
      repeat (2) @(posedge clk_sys);
      chk("irq clear", 32'h0, irq);
      apb(1'b1, o, 32'h03);
      rdc(o, 32'hFF, 32'h03, "ctl forced");
      chk("toggle out", 32'h0, ep_txv[e].toggle);
    end
    apb(1'b1, `UECR_IDX_EP2RX, 32'h40);
    apb(1'b1, `UECR_IDX_EP2TX, 32'h06);
    rdc(`UECR_IDX_EP2TX, 32'h07, 32'h07, "upload hs locked");
    u_host.in_xfer(2);
    rdc(`UECR_IDX_EP2TX, 32'h07, 32'h03, "upload keeps valid");
    chk("irq in upload", 32'h0, irq);
    rdc(`UECR_IDX_ISTR, 32'h80, 32'h00, "upload no transfer bit");
    apb(1'b1, `UECR_IDX_EP2RX, 32'h80);
    apb(1'b1, `UECR_IDX_EP2RX, 32'h83);
    rdc(`UECR_IDX_EP2RX, 32'hC3, 32'h80, "download rx hs locked");
    apb(1'b1, `UECR_IDX_EP2RX, 32'h00);
    apb(1'b1, `UECR_IDX_EP1TX, 32'h07);
    apb(1'b1, `UECR_IDX_EP2TX, 32'h07);
    u_host.bus_reset();
    rdc(`UECR_IDX_EP2TX, 32'h07, 32'h00, "ep2 after bus reset");
    rdc(`UECR_IDX_EP1TX, 32'h07, 32'h00, "ep1 after bus reset");
    rdc(`UECR_IDX_ISTR, 32'h02, 32'h02, "reset status");
    apb(1'b1, `UECR_IDX_CTL, 32'h07);
    apb(1'b1, `UECR_IDX_EP2TX, 32'h07);
    rdc(`UECR_IDX_EP2TX, 32'h07, 32'h00, "ep2 under forced reset");
    apb(1'b1, `UECR_IDX_CTL, 32'h06);
    give_verdict;
  end
endmodule

bind uecr_top uecr_properties #(.NEP(NEP), .CW01(CW01), .CW2(CW2)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .usb_reset_seen(usb_reset_seen), .ep_ev(ep_ev), .ep_txv(ep_txv), .rx_tog(rx_tog),
  .irq(irq));

// ==== uecr_top.sv ====
`timescale 1ns/10ps
// Endpoint transfer control and byte counters of a full-speed USB device.
// Assumes an APB master on clk_sys and a serial engine giving one-cycle events.
//
// Summary of operation
// - Any USB reset, detected or forced, clears transmit toggle and handshake state.
// - Endpoint 2 done flag sets on a correct transmit outside upload mode, stays until software clears.
// - Transmit toggle holds next data PID: 0 DATA0, 1 DATA1; hardware updates it.
// - Software may write transmit and receive toggles directly.
// - Handshake state: 00 disabled, 01 stall, 10 NAK, 11 valid.
// - Stall state answers STALL, NAK state answers NAK to every request.
// - A correct transfer forces the handshake state to NAK, except an endpoint 2 IN in upload mode, which stays valid.
// - Writes to endpoint 2 transmit handshake state are ignored in upload mode.
// - Endpoints 0 and 1 use five-bit receive counters limiting the next reception.
// - After reception the counter holds the loaded maximum minus bytes received.
// - Endpoint 2 uses a seven-bit receive counter decremented by bytes received.
// - Endpoints 0 and 1 send their five-bit transmit count on IN.
// - Endpoint 2 sends its seven-bit transmit count on IN.
// - Transmit toggle flips only after the host acknowledges the packet.
// - Endpoint 2 mode 01 is upload mode, IN served by hardware.
// - Upload mode IN raises no correct-transfer interrupt; OUT as normal.
`include "uecr_map.svh"
module uecr_top
  import uecr_pkg::*;
#(
  parameter int NEP  = 3,
  parameter int CW01 = 5,
  parameter int CW2  = 7
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Serial engine events, one per endpoint
  input  wire logic          usb_reset_seen,
  input  uecr_ev_t [NEP-1:0] ep_ev,
  // Transmit view for each endpoint
  output uecr_txv_t [NEP-1:0] ep_txv,
  output logic [NEP-1:0]     rx_tog,
  // Interrupt
  output logic               irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic       setup;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       mapped;
  logic       aligned;
  logic       in_range;
  logic [7:0] rdata;

  assign setup = psel && !penable;
  assign idx   = paddr[`UECR_ADDR_LSB +: `UECR_ADDR_W];
  assign wr    = psel && penable && pwrite && pready;
  assign rd    = psel && penable && !pwrite && pready;
  // Byte lanes below the word and pages above the map are not decoded
  assign aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign in_range = ((idx >= `UECR_IDX_ISTR) && (idx <= `UECR_IDX_C2TX)) ||
                    (idx == `UECR_IDX_BUFCS);
  assign mapped   = aligned && in_range;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // No wait states: data is registered during setup, answered in access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `UECR_WORD_ZERO;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= {24'h00_0000, rdata};
      end
    end
  end

  // ---------------------------------------------------------------
  // General registers
  // ---------------------------------------------------------------
  logic [7:0]     istr_reg;
  logic [7:0]     imr_reg;
  logic [7:0]     ctl_reg;
  logic [7:0]     device_address_reg;
  logic [7:0]     bufcs_reg;
  logic           usb_rst_any;
  logic           rst_meta;
  logic           rst_sync;
  uecr_mode_t     mode_reg;
  logic [NEP-1:0] tx_done;
  logic [NEP-1:0] rx_done_reg;
  logic [NEP-1:0] txdp;
  logic [NEP-1:0] rxdp;
  logic           ctr_any;

  // The bus reset indication comes from the line side, resync first
  // Two cycles of latency are the price of a metastability-safe input
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= usb_reset_seen;
      rst_sync <= rst_meta;
    end
  end

  // A held force-reset keeps every endpoint's toggle and handshake state cleared; writes to those fields meanwhile are lost
  assign usb_rst_any = rst_sync || ctl_reg[`UECR_CTL_FORCE_BUS_RESET];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      imr_reg   <= `UECR_IMR_RST;
      ctl_reg   <= `UECR_CTL_RST;
      device_address_reg <= `UECR_BYTE_ZERO;
      bufcs_reg <= `UECR_BYTE_ZERO;
    end else if (wr) begin
      if (hit(idx, `UECR_IDX_IMR)) imr_reg <= pwdata[7:0];
      if (hit(idx, `UECR_IDX_CTL)) ctl_reg <= pwdata[7:0];
      if (hit(idx, `UECR_IDX_DEVICE_ADDRESS)) device_address_reg <= {1'b0, pwdata[6:0]};
      if (hit(idx, `UECR_IDX_BUFCS)) bufcs_reg <= {4'h0, pwdata[3:0]};
    end
  end

  // Any correct transfer except an endpoint 2 IN in upload mode raises the shared bit
  assign ctr_any = (|txdp) || (|rxdp);

  // Sticky status, cleared by reading it; a new event in that cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      istr_reg <= `UECR_ISTR_RST;
    end else begin
      istr_reg <= ((rd && hit(idx, `UECR_IDX_ISTR)) ? `UECR_BYTE_ZERO : istr_reg)
                | ({7'h00, ctr_any} << `UECR_ISTR_CTR)
                | ({7'h00, rst_sync} << `UECR_ISTR_RESET);
    end
  end

  // Registered so the pin cannot glitch; it trails the status bit by a cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istr_reg & imr_reg);
    end
  end

  // ---------------------------------------------------------------
  // Endpoint transmit control
  // ---------------------------------------------------------------
  logic [NEP-1:0] tx_tog;
  uecr_hs_t       tx_hs [NEP];
  uecr_hs_t       rx_hs [NEP];
  logic [7:0]     txctl_idx [NEP];
  logic [7:0]     rxctl_idx [NEP];
  logic [7:0]     txcnt_idx [NEP];
  logic [7:0]     rxcnt_idx [NEP];
  logic [CW2-1:0] tx_cnt [NEP];
  logic [CW2-1:0] rx_cnt [NEP];

  assign txctl_idx = '{`UECR_IDX_EP0, `UECR_IDX_EP1TX, `UECR_IDX_EP2TX};
  assign rxctl_idx = '{`UECR_IDX_EP0, `UECR_IDX_EP1RX, `UECR_IDX_EP2RX};
  assign txcnt_idx = '{`UECR_IDX_C0TX, `UECR_IDX_C1TX, `UECR_IDX_C2TX};
  assign rxcnt_idx = '{`UECR_IDX_C0RX, `UECR_IDX_C1RX, `UECR_IDX_C2RX};

  // Control endpoint packs both directions in one register
  // Bits 6 and 5:4 go onto the toggle and state lanes; bit 7 lands on bit 4, so the done lane is 0
  function automatic logic [7:0] tx_view(input int e, input logic [7:0] d);
    tx_view = (e == 0) ? {d[7], 1'b0, 1'b0, d[7], 1'b0, d[6], d[5:4]} : d;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NEP; g++) begin : g_ep
      logic       up;
      logic       txw;
      logic [7:0] wd;
      logic       clr;
      logic       rxw;
      logic       rx_clr;
      logic       rx_locked;
      localparam int CW = (g == 2) ? CW2 : CW01;

      assign up  = (g == 2) && (mode_reg == UECR_MODE_UPLOAD);
      assign txw = wr && hit(idx, txctl_idx[g]);
      assign wd  = tx_view(g, pwdata[7:0]);
      assign clr = txw && !wd[`UECR_EP_DONE];
      assign rxw = wr && hit(idx, rxctl_idx[g]);
      // Control endpoint keeps its done flag in bit 7 for both directions
      assign rx_clr = rxw && !pwdata[(g == 0) ? `UECR_EP0_DONE : `UECR_EP_DONE];
      // Download mode hands the receive handshake to the buffer hardware
      assign rx_locked = (g == 2) && (mode_reg == UECR_MODE_DOWNLOAD);

      uecr_txep #(
        .CW         (CW)
      ) u_tx (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .bus_reset  (usb_rst_any),
        .wr_en      (txw),
        .wr_data    (wd),
        .hs_locked  (up),
        .clr_done   (clr),
        .in_token   (ep_ev[g].in_token),
        .host_ack   (ep_ev[g].host_ack),
        .hw_mode    (up),
        .done_reg   (tx_done[g]),
        .tog_reg    (tx_tog[g]),
        .hs_reg     (tx_hs[g]),
        .done_pulse (txdp[g])
      );

      // Answer toward the serial engine, registered
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          ep_txv[g] <= '0;
        end else begin
          case (tx_hs[g])
            UECR_HS_STALL: ep_txv[g].answer <= UECR_ANS_STALL;
            UECR_HS_NAK:   ep_txv[g].answer <= UECR_ANS_NAK;
            UECR_HS_VALID: ep_txv[g].answer <= UECR_ANS_DATA;
            default:       ep_txv[g].answer <= UECR_ANS_NONE;
          endcase
          ep_txv[g].toggle   <= tx_tog[g];
          ep_txv[g].tx_bytes <= tx_cnt[g];
        end
      end

      // Transmit counter, software loaded
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          tx_cnt[g] <= `UECR_CNT_RST;
        end else if (wr && hit(idx, txcnt_idx[g])) begin
          tx_cnt[g] <= CW2'(pwdata[CW-1:0]);
        end
      end

      // ---------------------------------------------------------------
      // Endpoint receive control
      // ---------------------------------------------------------------
      // Receive counter: loaded maximum, left holding the remainder
      // An overrun floors at zero rather than wrapping to a large remainder
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          rx_cnt[g] <= `UECR_CNT_RST;
        end else if (ep_ev[g].rx_done && rx_hs[g] == UECR_HS_VALID) begin
          rx_cnt[g] <= (ep_ev[g].rx_bytes > rx_cnt[g]) ? `UECR_CNT_RST
                     : rx_cnt[g] - ep_ev[g].rx_bytes;
        end else if (wr && hit(idx, rxcnt_idx[g])) begin
          rx_cnt[g] <= CW2'(pwdata[CW-1:0]);
        end
      end

      // Receive side control, same handshake rules
      assign rxdp[g] = ep_ev[g].rx_done && rx_hs[g] == UECR_HS_VALID;
      always_ff @(posedge clk_sys) begin
        if (!rst_n || usb_rst_any) begin
          rx_tog[g] <= 1'b0;
          rx_hs[g]  <= UECR_HS_DISABLED;
        end else if (rxdp[g]) begin
          rx_tog[g] <= !rx_tog[g];
          rx_hs[g]  <= UECR_HS_NAK;
        end else if (rxw) begin
          rx_tog[g] <= pwdata[`UECR_EP_TOG];
          if (!rx_locked) begin
            rx_hs[g] <= uecr_hs_t'(pwdata[1:0]);
          end
        end
      end

      // Set wins over a clear in the same cycle
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          rx_done_reg[g] <= 1'b0;
        end else if (rxdp[g]) begin
          rx_done_reg[g] <= 1'b1;
        end else if (rx_clr) begin
          rx_done_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Endpoint 2 mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_reg <= UECR_MODE_NORMAL;
    end else if (wr && hit(idx, `UECR_IDX_EP2RX)) begin
      mode_reg <= uecr_mode_t'(pwdata[`UECR_EP2_MODE_HI:`UECR_EP2_MODE_LO]);
    end
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  logic ep0_done;

  // Control endpoint reports one done flag for both directions
  assign ep0_done = tx_done[0] | rx_done_reg[0];

  always_comb begin
    rdata = `UECR_BYTE_ZERO;
    case (idx)
      `UECR_IDX_ISTR:  rdata = istr_reg;
      `UECR_IDX_IMR:   rdata = imr_reg;
      `UECR_IDX_CTL:   rdata = ctl_reg;
      `UECR_IDX_DEVICE_ADDRESS: rdata = device_address_reg;
      `UECR_IDX_BUFCS: rdata = bufcs_reg;
      `UECR_IDX_EP0:   rdata = {ep0_done, tx_tog[0], tx_hs[0],
                                1'b0, rx_tog[0], rx_hs[0]};
      `UECR_IDX_EP1RX: rdata = {4'h0, rx_done_reg[1], rx_tog[1], rx_hs[1]};
      `UECR_IDX_EP1TX: rdata = {4'h0, tx_done[1], tx_tog[1], tx_hs[1]};
      `UECR_IDX_EP2RX: rdata = {mode_reg, 2'h0, rx_done_reg[2], rx_tog[2], rx_hs[2]};
      `UECR_IDX_EP2TX: rdata = {4'h0, tx_done[2], tx_tog[2], tx_hs[2]};
      `UECR_IDX_C0RX:  rdata = {1'b0, rx_cnt[0]};
      `UECR_IDX_C0TX:  rdata = {1'b0, tx_cnt[0]};
      `UECR_IDX_C1RX:  rdata = {1'b0, rx_cnt[1]};
      `UECR_IDX_C1TX:  rdata = {1'b0, tx_cnt[1]};
      `UECR_IDX_C2RX:  rdata = {1'b0, rx_cnt[2]};
      `UECR_IDX_C2TX:  rdata = {1'b0, tx_cnt[2]};
      default:         rdata = `UECR_BYTE_ZERO;
    endcase
  end

endmodule

// ==== uecr_txep.sv ====
`timescale 1ns/10ps
// Transmit control of one endpoint: toggle, handshake state, done flag.
// Assumes single-cycle event pulses from logic on clk_sys.
`include "uecr_map.svh"
module uecr_txep
  import uecr_pkg::*;
#(
  parameter int CW = 7
) (
  // Clock and resets
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          bus_reset,
  // Software access
  input  wire logic          wr_en,
  input  wire logic [7:0]    wr_data,
  input  wire logic          hs_locked,
  input  wire logic          clr_done,
  // Link events
  input  wire logic          in_token,
  input  wire logic          host_ack,
  input  wire logic          hw_mode,
  // State
  output logic               done_reg,
  output logic               tog_reg,
  output uecr_hs_t           hs_reg,
  output logic               done_pulse
);

  logic good_tx;

  // Only an ACK after our own data packet completes the transfer
  assign good_tx = host_ack && (hs_reg == UECR_HS_VALID);
  assign done_pulse = good_tx && !hw_mode;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || bus_reset) begin
      tog_reg <= 1'b0;
      hs_reg  <= UECR_HS_DISABLED;
    end else if (good_tx) begin
      tog_reg <= !tog_reg;
      if (!hw_mode) begin
        hs_reg <= UECR_HS_NAK;
      end
    end else if (wr_en) begin
      tog_reg <= wr_data[`UECR_EP_TOG];
      if (!hs_locked) begin
        hs_reg <= uecr_hs_t'(wr_data[1:0]);
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (done_pulse) begin
      done_reg <= 1'b1;
    end else if (clr_done) begin
      done_reg <= 1'b0;
    end
  end

endmodule
